/* File: rtl/dmc_pkg.sv */
// Constants, the carrier struct and the state encoding of the direct-mapped write-through cache controller
package dmc_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W   = 24;
    localparam int DATA_W   = 16;
    localparam int BE_W     = DATA_W / 8;
    localparam int IDX_W    = 13;
    localparam int TAG_W    = ADDR_W - IDX_W;
    localparam int VALID_W  = 5;
    localparam int SLICE_W  = 8;
    localparam int CMP_W    = TAG_W + VALID_W;
    localparam int SLICES   = CMP_W / SLICE_W;
    localparam logic [VALID_W-1:0] VALID_ONES = 5'h1_F;
    localparam logic [BE_W-1:0]    BE_FULL    = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS     = 50;
    localparam int STROBE_NS  = 37;
    localparam int MEMCYC_NS  = 100;
    // Least time, so round up; never below one cycle
    localparam int STROBE_CYC = ((STROBE_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
                                : ((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam int CNT_W      = 4;

    // ------------------------------------------------------------
    // Uncached I/O window defaults
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IO_BASE_DEF = 24'hFF_0000;
    localparam logic [ADDR_W-1:0] IO_MASK_DEF = 24'hFF_0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              req;
        logic              we;
        logic [BE_W-1:0]   be;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dmc_cyc_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOOK = 2'b01,
        ST_MEM  = 2'b11
    } dmc_state_e;

endpackage

/* File: rtl/dmc_tag_slice.sv */
// One 8-bit tag slice: tag storage, flash clear and equality comparator
`timescale 1ns/10ps
module dmc_tag_slice
    import dmc_pkg::*;
#(
    parameter int W     = SLICE_W,
    parameter int AW    = IDX_W
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rstn,
    // Control
    input  wire logic          clr,
    input  wire logic          wr,
    input  wire logic [AW-1:0] idx,
    input  wire logic [W-1:0]  cmp,
    // Result
    output logic               match
);

    logic [W-1:0]        cells [2**AW];
    logic [2**AW-1:0]    live_q;
    logic [W-1:0]        stored;

    // ------------------------------------------------------------
    // Flash clear
    // ------------------------------------------------------------
    // A live flag per entry stands in for zeroing every cell; a cleared
    // entry reads as all zeros, so the whole store empties in one edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            live_q <= '0;
        end else if (clr) begin
            live_q <= '0;
        end else if (wr) begin
            live_q[idx] <= 1'b1;
        end
    end

    // Storage write, no reset needed behind the live flags
    always_ff @(posedge clk) begin
        if (wr && !clr) begin
            cells[idx] <= cmp;
        end
    end

    // ------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------
    assign stored = live_q[idx] ? cells[idx] : '0;
    assign match  = (stored == cmp);

endmodule

/* File: rtl/dmc_cache_ctrl.sv */
// Direct-mapped write-through cache controller with tag slices and data store
`timescale 1ns/10ps
module dmc_cache_ctrl
    import dmc_pkg::*;
#(
    parameter logic [ADDR_W-1:0] IO_BASE = IO_BASE_DEF,
    parameter logic [ADDR_W-1:0] IO_MASK = IO_MASK_DEF
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Cache control
    input  wire logic              tag_clr,
    input  wire logic              buf_wr_en,
    // Processor side
    input  wire dmc_cyc_s          cpu_cyc,
    output logic                   cpu_hit,
    output logic                   cpu_done,
    output logic [DATA_W-1:0]      cpu_rdata,
    // Main memory side
    output dmc_cyc_s               mem_cyc,
    input  wire logic              mem_ack,
    input  wire logic [DATA_W-1:0] mem_rdata
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        dmc_state_e        st;
        logic [CNT_W-1:0]  cnt;
        dmc_cyc_s          cur;
        logic              io;
        logic              hit;
        logic              done;
        logic [DATA_W-1:0] rdata;
        dmc_cyc_s          mem;
    } dmc_ctl_s;

    localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYC - 1);

    dmc_ctl_s q;
    dmc_ctl_s d;

    logic [DATA_W-1:0] data_mem [2**IDX_W];

    logic [IDX_W-1:0]  idx;
    logic [TAG_W-1:0]  tag;
    logic [CMP_W-1:0]  cmp_word;
    logic [SLICES-1:0] slice_match;
    logic              match_all;
    logic              io_now;
    logic              full_word;
    logic              tag_wr;
    logic [BE_W-1:0]   data_be;
    logic [DATA_W-1:0] data_wv;
    logic [DATA_W-1:0] cache_word;

    // ------------------------------------------------------------
    // Address split and uncached decode
    // ------------------------------------------------------------
    // Index and tag come from the captured address so they hold
    // steady across the whole cycle even if the bus moves on
    assign idx       = q.cur.addr[IDX_W-1:0];
    assign tag       = q.cur.addr[ADDR_W-1:IDX_W];
    assign cmp_word  = {VALID_ONES, tag};
    assign io_now    = ((cpu_cyc.addr & IO_MASK) == IO_BASE);
    assign full_word = (q.cur.be == BE_FULL);
    assign cache_word = data_mem[idx];

    // ------------------------------------------------------------
    // Tag slices
    // ------------------------------------------------------------
    for (genvar s = 0; s < SLICES; s++) begin : g_slice
        dmc_tag_slice #(
            .W    (SLICE_W),
            .AW   (IDX_W)
        ) u_slice (
            .clk   (clk),
            .rstn  (rstn),
            .clr   (tag_clr),
            .wr    (tag_wr),
            .idx   (idx),
            .cmp   (cmp_word[s*SLICE_W +: SLICE_W]),
            .match (slice_match[s])
        );
    end

    // Wired-AND of the slices; an I/O access never counts as a hit
    assign match_all = &slice_match;
    assign cpu_hit   = match_all && !q.io && (q.st == ST_LOOK);

    // ------------------------------------------------------------
    // Control sequence
    // ------------------------------------------------------------
    // One request is taken in idle; the timing strobe falls STROBE_CYC
    // cycles later in the look state, where the hit is latched and the
    // choice between cache and main memory is made
    always_comb begin
        d       = q;
        d.done  = 1'b0;
        tag_wr  = 1'b0;
        data_be = '0;
        data_wv = q.cur.wdata;

        // Memory handshake retires any outstanding cycle, buffered or not
        if (q.mem.req && mem_ack) begin
            d.mem.req = 1'b0;
        end

        case (q.st)
            ST_IDLE: begin
                if (cpu_cyc.req) begin
                    d.cur = cpu_cyc;
                    d.io  = io_now;
                    d.cnt = STROBE_LOAD;
                    d.st  = ST_LOOK;
                end
            end

            ST_LOOK: begin
                if (q.cnt != '0) begin
                    d.cnt = q.cnt - CNT_W'(1);
                end else begin
                    d.hit = match_all && !q.io;
                    if (!q.cur.we && match_all && !q.io) begin
                        // Read hit: main memory never started
                        d.rdata = cache_word;
                        d.done  = 1'b1;
                        d.st    = ST_IDLE;
                    end else if (q.mem.req) begin
                        // Buffered write still draining; a miss or a
                        // second write must wait so order is kept
                        d.st = ST_LOOK;
                    end else if (q.cur.we && buf_wr_en) begin
                        // Capture and finish at cache speed
                        d.mem = q.cur;
                        d.mem.req = 1'b1;
                        if (!q.io && (full_word || match_all)) begin
                            data_be = q.cur.be;
                            tag_wr  = full_word;
                        end
                        d.done = 1'b1;
                        d.st   = ST_IDLE;
                    end else begin
                        // Miss, I/O, or unbuffered write through
                        d.mem     = q.cur;
                        d.mem.req = 1'b1;
                        d.st      = ST_MEM;
                    end
                end
            end

            ST_MEM: begin
                if (q.mem.req && mem_ack) begin
                    d.done = 1'b1;
                    d.st   = ST_IDLE;
                    if (!q.cur.we) begin
                        d.rdata = mem_rdata;
                        data_wv = mem_rdata;
                        if (!q.io) begin
                            // Fill replaces whatever line held this index
                            data_be = BE_FULL;
                            tag_wr  = 1'b1;
                        end
                    end else if (!q.io && (full_word || q.hit)) begin
                        // Latched hit gates the partial write
                        data_be = q.cur.be;
                        tag_wr  = full_word;
                    end
                end
            end

            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // A clear beats any fill in the same edge
        if (tag_clr) begin
            tag_wr = 1'b0;
        end
        // No data or tag ever written for uncached space
        if (q.io) begin
            tag_wr  = 1'b0;
            data_be = '0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{st: ST_IDLE, cnt: '0, cur: '0, io: 1'b0, hit: 1'b0,
                   done: 1'b0, rdata: '0, mem: '0};
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Cache data store with byte lanes
    // ------------------------------------------------------------
    // Not cleared at reset; the tag valid bits keep stale words unseen
    always_ff @(posedge clk) begin
        for (int b = 0; b < BE_W; b++) begin
            if (data_be[b]) begin
                data_mem[idx][b*8 +: 8] <= data_wv[b*8 +: 8];
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cpu_done  = q.done;
    assign cpu_rdata = q.rdata;
    assign mem_cyc   = q.mem;

endmodule

/* File: verification/dmc_properties.sv */
// Port checker for the cache controller, bound to its top module
`timescale 1ns/10ps
module dmc_properties
    import dmc_pkg::*;
#(
    parameter logic [ADDR_W-1:0] IO_BASE = IO_BASE_DEF,
    parameter logic [ADDR_W-1:0] IO_MASK = IO_MASK_DEF
) (
    // Clock, reset, control
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              tag_clr,
    input wire logic              buf_wr_en,
    // Processor and memory
    input wire dmc_cyc_s          cpu_cyc,
    input wire logic              cpu_hit,
    input wire logic              cpu_done,
    input wire logic [DATA_W-1:0] cpu_rdata,
    input wire dmc_cyc_s          mem_cyc,
    input wire logic              mem_ack,
    input wire logic [DATA_W-1:0] mem_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Read hit: look cycle, then finish without a memory cycle
    sequence s_look_rd; cpu_hit && !cpu_cyc.we; endsequence
    sequence s_cache_end; cpu_done && !$rose(mem_cyc.req); endsequence
    property p_hit_fast; s_look_rd |=> s_cache_end; endproperty
    a_hit_fast: assert property (p_hit_fast) else $error("read hit not from cache");
    property p_io_miss; cpu_hit |-> (cpu_cyc.addr & IO_MASK) != IO_BASE; endproperty
    a_io_miss: assert property (p_io_miss) else $error("hit on io address");
    property p_mem_hold; mem_cyc.req && !mem_ack |=> mem_cyc.req && $stable(mem_cyc); endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("memory cycle dropped early");
    property p_mem_start;
        $rose(mem_cyc.req) |-> mem_cyc.addr == cpu_cyc.addr && mem_cyc.we == cpu_cyc.we && mem_cyc.be == cpu_cyc.be;
    endproperty
    a_mem_start: assert property (p_mem_start) else $error("memory cycle differs from request");
    property p_rd_fill; mem_ack && mem_cyc.req && !mem_cyc.we |=> cpu_done && cpu_rdata == $past(mem_rdata); endproperty
    a_rd_fill: assert property (p_rd_fill) else $error("miss data not returned");
    property p_wr_slow; mem_ack && mem_cyc.req && mem_cyc.we && !buf_wr_en |=> cpu_done; endproperty
    a_wr_slow: assert property (p_wr_slow) else $error("unbuffered write not ended");
    property p_buf_fast; $rose(mem_cyc.req) && mem_cyc.we && buf_wr_en |-> cpu_done; endproperty
    a_buf_fast: assert property (p_buf_fast) else $error("buffered write slow");
    property p_clr; tag_clr |=> !cpu_hit; endproperty
    a_clr: assert property (p_clr) else $error("hit after clear");
    property p_wait_mem; $rose(mem_cyc.req) && !mem_cyc.we |-> !cpu_done; endproperty
    a_wait_mem: assert property (p_wait_mem) else $error("read miss ended before memory");
endmodule
bind dmc_cache_ctrl dmc_properties #(.IO_BASE(IO_BASE), .IO_MASK(IO_MASK)) u_props (.clk(clk), .rstn(rstn),
    .tag_clr(tag_clr), .buf_wr_en(buf_wr_en), .cpu_cyc(cpu_cyc), .cpu_hit(cpu_hit), .cpu_done(cpu_done),
    .cpu_rdata(cpu_rdata), .mem_cyc(mem_cyc), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

/* File: verification/dmc_mem_model.sv */
// Behavioural main memory answering the controller's memory cycles
`timescale 1ns/10ps
module dmc_mem_model
    import dmc_pkg::*;
(
    // Clock, reset, pacing
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [3:0]        lat,
    // Memory cycle
    input  wire dmc_cyc_s          mem_cyc,
    output logic                   mem_ack,
    output logic [DATA_W-1:0]      mem_rdata
);
    logic [DATA_W-1:0] m [logic [ADDR_W-1:0]];
    logic [3:0]        cnt;
    logic [DATA_W-1:0] o;
    // Unwritten words carry an address pattern so tags see distinct data
    function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
        return m.exists(a) ? m[a] : a[15:0] ^ {a[23:16], 8'h3C};
    endfunction
    // Ack after lat waits; idle data bus toggles so stale data never looks valid
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0000;
            cnt <= 4'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_ack)
                cnt <= 4'h0;
            else if (mem_cyc.req && cnt >= lat) begin
                o = rd(mem_cyc.addr);
                mem_ack <= 1'b1;
                mem_rdata <= o;
                if (mem_cyc.we)
                    m[mem_cyc.addr] = {mem_cyc.be[1] ? mem_cyc.wdata[15:8] : o[15:8],
                                       mem_cyc.be[0] ? mem_cyc.wdata[7:0] : o[7:0]};
            end else if (mem_cyc.req)
                cnt <= cnt + 4'h1;
        end
    end
endmodule

/* File: verification/test_direct_mapped_write_through_cache.sv */
// Self-checking bench for the direct-mapped write-through cache controller
`timescale 1ns/10ps
module test_direct_mapped_write_through_cache
    import dmc_pkg::*;
;
    logic              clk = 1'b0;
    logic              rstn;
    logic              tag_clr;
    logic              buf_wr_en;
    logic [3:0]        lat;
    dmc_cyc_s          cpu_cyc;
    logic              cpu_hit;
    logic              cpu_done;
    logic [DATA_W-1:0] cpu_rdata;
    dmc_cyc_s          mem_cyc;
    logic              mem_ack;
    logic [DATA_W-1:0] mem_rdata;
    int                n_fail;
    int                n_checks;
    logic [15:0]       sh [logic [23:0]];
    localparam logic [23:0] A = 24'h01_0123;
    localparam logic [23:0] B = 24'h01_2123;
    localparam logic [23:0] C = 24'h02_0456;
    localparam logic [23:0] D = 24'h03_0789;
    localparam logic [23:0] E = 24'h04_0AB0;
    localparam logic [23:0] IO = 24'hFF_0040;
    localparam logic [23:0] X = 24'h00_0040;

    dmc_cache_ctrl dut (.clk(clk), .rstn(rstn), .tag_clr(tag_clr), .buf_wr_en(buf_wr_en), .cpu_cyc(cpu_cyc),
        .cpu_hit(cpu_hit), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .mem_cyc(mem_cyc), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    dmc_mem_model u_mem (.clk(clk), .rstn(rstn), .lat(lat), .mem_cyc(mem_cyc), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    // 50 ns processor clock
    initial begin
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    function automatic logic [15:0] ex(input logic [23:0] a);
        return sh.exists(a) ? sh[a] : a[15:0] ^ {a[23:16], 8'h3C};
    endfunction

    // One processor cycle; req held until done, as the processor stalls
    task automatic acc(input logic w, input logic [1:0] b, input logic [23:0] a, input logic [15:0] d,
                       input logic eh, input int en);
        logic        h;
        int          n;
        logic [15:0] o;
        h = 1'b0;
        n = 0;
        o = ex(a);
        cpu_cyc = '{1'b1, w, b, a, d};
        while (cpu_done !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
            if (cpu_hit === 1'b1)
                h = 1'b1;
        end
        chk(cpu_done, 1'b1);
        chk(h, eh);
        if (en > 0)
            chk(n, en);
        if (!w)
            chk(cpu_rdata, o);
        else
            sh[a] = {b[1] ? d[15:8] : o[15:8], b[0] ? d[7:0] : o[7:0]};
        cpu_cyc.req = 1'b0;
        @(negedge clk);
    endtask

    task automatic t_read_replace();
        acc(1'b0, 2'h3, A, 16'h0000, 1'b0, 0);
        acc(1'b0, 2'h3, A, 16'h0000, 1'b1, 2);
        acc(1'b0, 2'h3, B, 16'h0000, 1'b0, 0);
        acc(1'b0, 2'h3, A, 16'h0000, 1'b0, 0);
        acc(1'b0, 2'h3, A, 16'h0000, 1'b1, 2);
    endtask

    task automatic t_write();
        lat = 4'h3;
        acc(1'b1, 2'h3, C, 16'h1234, 1'b0, 0);
        chk(u_mem.m[C], 16'h1234);
        acc(1'b0, 2'h3, C, 16'h0000, 1'b1, 2);
        acc(1'b1, 2'h1, D, 16'hAB55, 1'b0, 0);
        acc(1'b0, 2'h3, D, 16'h0000, 1'b0, 0);
        acc(1'b1, 2'h2, A, 16'h9900, 1'b1, 0);
        acc(1'b0, 2'h3, A, 16'h0000, 1'b1, 2);
    endtask

    // X shares its index with IO; an I/O fill would evict it
    task automatic t_io_clr();
        acc(1'b0, 2'h3, X, 16'h0000, 1'b0, 0);
        acc(1'b0, 2'h3, IO, 16'h0000, 1'b0, 0);
        acc(1'b1, 2'h3, IO, 16'h5A5A, 1'b0, 0);
        acc(1'b0, 2'h3, IO, 16'h0000, 1'b0, 0);
        acc(1'b0, 2'h3, X, 16'h0000, 1'b1, 2);
        tag_clr = 1'b1;
        @(negedge clk);
        tag_clr = 1'b0;
        acc(1'b0, 2'h3, A, 16'h0000, 1'b0, 0);
        acc(1'b0, 2'h3, C, 16'h0000, 1'b0, 0);
    endtask

    // Slow memory: buffered write ends at cache speed, hit read during drain
    task automatic t_buf();
        buf_wr_en = 1'b1;
        lat = 4'h6;
        acc(1'b1, 2'h3, E, 16'h4321, 1'b0, 2);
        acc(1'b0, 2'h3, E, 16'h0000, 1'b1, 2);
        acc(1'b0, 2'h3, B, 16'h0000, 1'b0, 0);
        chk(u_mem.m[E], 16'h4321);
        acc(1'b1, 2'h1, E, 16'h00AA, 1'b1, 2);
        acc(1'b0, 2'h3, E, 16'h0000, 1'b1, 2);
        acc(1'b1, 2'h3, E, 16'h5555, 1'b1, 0);
        acc(1'b0, 2'h3, D, 16'h0000, 1'b0, 0);
        chk(u_mem.m[E], 16'h5555);
    endtask

    // Mid-run reset must empty the tags like a clear
    task automatic t_reset();
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        chk({cpu_done, cpu_hit, mem_cyc.req}, 3'h0);
        rstn = 1'b1;
        @(negedge clk);
        acc(1'b0, 2'h3, D, 16'h0000, 1'b0, 0);
    endtask

    task automatic end_sim();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        rstn = 1'b0;
        tag_clr = 1'b0;
        buf_wr_en = 1'b0;
        lat = 4'h0;
        cpu_cyc = '0;
        n_fail = 0;
        n_checks = 0;
        repeat (8) @(negedge clk);
        chk({cpu_done, cpu_hit, mem_cyc.req}, 3'h0);
        rstn = 1'b1;
        @(negedge clk);
        t_read_replace();
        t_write();
        t_io_clr();
        t_buf();
        t_reset();
        end_sim();
    end

    // Watchdog well past the expected run of a few hundred cycles
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
endmodule
